// >>> rtl/video_serial_word_framer.sv
// serial word framer with axi4-lite configuration registers
// Function
// [R1] shift serial words out lsb first
// [R2] 18-bit width: coding, sync, sixteen data
// [R3] narrower widths give shorter words same order
// [R4] parity 16-bit: parity pair leads 20-bit word
// [R5] parity narrower widths: parity pair then rest
// [R6] bit clock equals pixel clock times length
// [R7] host reprograms range on both ends together
// [R8] pixel clock range field decode
// [R9] serial rate range field decode
// [R10] host keeps bit rate under 840 mbps
// [R11] width field decode, 1xx means eighteen
// [R12] serializer spread field decode
// [R13] host limits spread at high pixel range
// [R14] host enables spread on one end only
// [R15] far end follows applied spread
// [R16] control traffic never spread modulated
// [R17] far end output spread field decode
// [R18] bypass bit disables jitter filter
// [R19] boost drive only on transitions
// [R20] edge bit picks input latch edge
// [R21] control phase starts on vsync active edge
// [R22] far end hsync polarity programmable
// [R23] gpio 8,9 always; 0-7 when width frees
// [R24] unavailable gpio bits have no effect
// [R25] source holds sync eight cycles after edge
// [R26] handshake of 546 or 1090 words before video
`include "video_framer_regs.svh"
`default_nettype none
module video_serial_word_framer
  import video_framer_pkg::*;
#(
  parameter int unsigned HSK_WORDS = 1090, // long handshake length
  parameter int unsigned CTRL_WORDS = 64 // idle words of control phase
) (
  input wire logic mclk_i, // bit clock, twenty times word rate max
  input wire logic reset_n_i, // synchronous, active low
  input wire logic pclk_pin_i, // pixel clock pin, sampled
  input wire logic hsync_i, // horizontal sync pin
  input wire logic vsync_i, // vertical sync pin
  input wire logic [15:0] data_i, // parallel video pins
  input wire logic [9:0] gpio_in_i, // gpio pins in
  input wire logic [31:0] s_axi_awaddr, // axi write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic serial_out_positive_o, // differential pair, true
  output logic serial_out_negative_o, // differential pair, inverted
  output logic boost_o, // preemphasis active this bit
  output logic [2:0] boost_level_o, // preemphasis level
  output logic [2:0] spread_code_o, // modulation code to analog
  output logic filter_bypass_o, // jitter filter pll bypass
  output logic [9:0] gpio_out_o, // gpio pins out
  output logic [9:0] gpio_oe_o, // gpio output enables
  output logic ctrl_phase_o, // control channel open
  output logic [4:0] word_len_o // active serial word length
);
  initial begin
    if (HSK_WORDS < 1 || HSK_WORDS > 65535 || CTRL_WORDS < 1 ||
        CTRL_WORDS > 65535) begin
      $error("framer parameters out of range");
    end
  end
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // data width in bits (without sync) from width field
  function automatic logic [4:0] data_bits(input logic [2:0] code);
    if (code[2]) begin
      data_bits = 5'd16; // [R11]
    end else begin
      data_bits = 5'd8 + {1'b0, code[1:0], 1'b0}; // [R11]
    end
  endfunction
  // serial length: data + sync + coding, parity trades two data bits at 16-bit width, else adds two bits
  function automatic logic [4:0] ser_len(input logic [2:0] code,
                                         input logic par);
    logic [4:0] n;
    n = data_bits(code) + 5'd4; // [R3]
    if (par && n > 5'd18) begin
      ser_len = 5'd20; // [R4]
    end else if (par) begin
      ser_len = n + 5'd2; // [R5]
    end else begin
      ser_len = n; // [R2]
    end
  endfunction
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] fmt_q; // range, rate, parity, width fields
  logic [7:0] spread_q; // spread field in [7:5]
  logic [7:0] edge_q; // edge polarity and filter bypass
  logic [7:0] boost_q; // preemphasis level in [7:5]
  logic [9:0] gpio_dir_q; // gpio direction, one is output
  logic [9:0] gpio_val_q; // gpio output values
  logic aw_hold_q, w_hold_q; // write channel captured
  logic [7:0] aw_q; // captured write address
  logic [31:0] w_q; // captured write data
  logic [3:0] ws_q; // captured strobes
  link_phase_t phase_q;
  logic [9:0] gpio_avail; // usable gpio mask
  logic [4:0] dbits; // current data width
  logic [9:0] gpio_in_s; // synced gpio inputs, for status
  logic load; // shifter wants the next word
  assign dbits = data_bits(fmt_q[2:0]);
  // pins 0-7 share data inputs 8-15; free above used data, or above two fewer data bits when parity is on
  always_comb begin
    gpio_avail = 10'h300; // [R23]
    for (int i = 0; i < 8; i++) begin
      if (5'(i + 8) >= dbits - (fmt_q[`FMT_PAR_BIT] ? 5'd2 : 5'd0)) begin
        gpio_avail[i] = 1'b1; // [R23]
      end
    end
  end
  // write address and data may arrive in either order
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
      aw_hold_q <= 1'b0; // commit cycle
      w_hold_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  // register commit and write response
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      fmt_q <= `RST_LINK_FORMAT;
      spread_q <= `RST_SPREAD_SEL;
      edge_q <= `RST_EDGE_FILTER;
      boost_q <= `RST_DRIVE_BOOST;
      gpio_dir_q <= 10'h000;
      gpio_val_q <= 10'h000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= 2'b00;
      if (!ws_q[0]) begin
        s_axi_bresp <= 2'b00; // no lane, nothing stored
      end else if (aw_q == `ADDR_LINK_FORMAT) begin
        fmt_q <= w_q[7:0]; // [R8] [R9] [R11]
      end else if (aw_q == `ADDR_SPREAD_SEL) begin
        spread_q <= w_q[7:0];
      end else if (aw_q == `ADDR_EDGE_FILTER) begin
        edge_q <= w_q[7:0];
      end else if (aw_q == `ADDR_DRIVE_BOOST) begin
        boost_q <= w_q[7:0];
      end else if (aw_q == `ADDR_GPIO_CTRL) begin
        gpio_val_q <= w_q[9:0];
        gpio_dir_q <= w_q[25:16];
      end else if (aw_q != `ADDR_STATUS) begin
        s_axi_bresp <= 2'b10; // unmapped slot
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // read channel, one cycle after address
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr[7:0] == `ADDR_LINK_FORMAT) begin
        s_axi_rdata <= {24'h00_0000, fmt_q};
      end else if (s_axi_araddr[7:0] == `ADDR_SPREAD_SEL) begin
        s_axi_rdata <= {24'h00_0000, spread_q};
      end else if (s_axi_araddr[7:0] == `ADDR_EDGE_FILTER) begin
        s_axi_rdata <= {24'h00_0000, edge_q};
      end else if (s_axi_araddr[7:0] == `ADDR_DRIVE_BOOST) begin
        s_axi_rdata <= {24'h00_0000, boost_q};
      end else if (s_axi_araddr[7:0] == `ADDR_STATUS) begin
        s_axi_rdata <= {15'h0000, gpio_in_s,
          ser_len(fmt_q[2:0], fmt_q[`FMT_PAR_BIT]), phase_q};
      end else if (s_axi_araddr[7:0] == `ADDR_GPIO_CTRL) begin
        s_axi_rdata <= {6'h00, gpio_dir_q, 6'h00, gpio_val_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10; // unmapped slot
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [28:0] sync1_q, sync2_q; // clk, hs, vs, data, gpio
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {pclk_pin_i, hsync_i, vsync_i, data_i, gpio_in_i};
      sync2_q <= sync1_q;
    end
  end
  assign gpio_in_s = sync2_q[9:0];
  // ----------------------------------------------------------------
  // pixel edge capture and word build
  // ----------------------------------------------------------------
  logic pclk_d_q, vs_d_q; // delayed synced levels
  logic pix_edge; // selected pixel clock edge
  logic vs_active; // selected vsync active edge
  logic [19:0] word_d; // word being framed
  logic [19:0] cap_q; // captured framed word
  logic cap_v_q; // capture pending for shifter
  logic [4:0] len;
  logic pclk_s, vs_s;
  assign pclk_s = sync2_q[28];
  assign vs_s = sync2_q[26];
  assign len = ser_len(fmt_q[2:0], fmt_q[`FMT_PAR_BIT]);
  assign pix_edge = edge_q[`EDGE_CLK_BIT] ? (pclk_s && !pclk_d_q)
                                          : (!pclk_s && pclk_d_q); // [R20]
  assign vs_active = edge_q[`EDGE_VSYNC_BIT] ? (vs_s && !vs_d_q)
                                             : (!vs_s && vs_d_q); // [R21]
  // coding bits alternate per word for dc balance
  logic code_q;
  always_comb begin
    logic [19:0] body;
    logic [17:0] sent; // sent bits only: far end cannot see the rest
    body = {sync2_q[25:10], sync2_q[26], sync2_q[27], ~code_q, code_q};
    sent = body[17:0] & ((18'h1 << (len - 5'd2)) - 18'h1);
    if (fmt_q[`FMT_PAR_BIT]) begin
      word_d = {body[17:0], ~(^sent), ^sent}; // [R4] [R5]
    end else begin
      word_d = body; // [R2] [R3]
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pclk_d_q <= 1'b0;
      vs_d_q <= 1'b0;
      cap_q <= 20'h0_0000;
      cap_v_q <= 1'b0;
      code_q <= 1'b0;
    end else begin
      pclk_d_q <= pclk_s;
      vs_d_q <= vs_s;
      if (pix_edge) begin
        cap_q <= word_d;
        cap_v_q <= 1'b1;
        code_q <= ~code_q;
      end else if (load) begin
        cap_v_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // shifter: len bits per word, lsb first
  // ----------------------------------------------------------------
  logic [19:0] sh_q; // shift register
  logic [4:0] bit_q; // bits left in word
  logic prev_q; // last bit sent, for boost
  logic [15:0] wcnt_q; // word counter in control or handshake
  assign load = (bit_q <= 5'd1);
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sh_q <= 20'h0_0000;
      bit_q <= 5'd0;
      prev_q <= 1'b0;
      serial_out_positive_o <= 1'b0;
      serial_out_negative_o <= 1'b1;
      boost_o <= 1'b0;
    end else begin
      if (load) begin
        // handshake and control send alternating fill, no video
        sh_q <= (phase_q == st_video && cap_v_q) ? cap_q : 20'h5_5555;
        bit_q <= len; // [R6]
      end else begin
        sh_q <= {1'b0, sh_q[19:1]}; // [R1]
        bit_q <= bit_q - 5'd1;
      end
      serial_out_positive_o <= sh_q[0]; // [R1]
      serial_out_negative_o <= ~sh_q[0];
      prev_q <= sh_q[0];
      boost_o <= (sh_q[0] != prev_q); // [R19]
    end
  end
  // ----------------------------------------------------------------
  // link phase
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      phase_q <= st_video;
      wcnt_q <= 16'h0000;
    end else begin
      case (phase_q)
        st_video: begin
          if (vs_active) begin
            phase_q <= st_control; // [R21]
            wcnt_q <= 16'h0000;
          end
        end
        st_control: begin
          if (load && wcnt_q == 16'(CTRL_WORDS - 1)) begin
            phase_q <= st_handshake;
            wcnt_q <= 16'h0000;
          end else if (load) begin
            wcnt_q <= wcnt_q + 16'h0001;
          end
        end
        default: begin
          if (load && wcnt_q == 16'(HSK_WORDS - 1)) begin
            phase_q <= st_video; // [R26]
          end else if (load) begin
            wcnt_q <= wcnt_q + 16'h0001;
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // analog-side controls and gpio
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      spread_code_o <= 3'h0;
      filter_bypass_o <= 1'b0;
      boost_level_o <= 3'h7;
      gpio_out_o <= 10'h000;
      gpio_oe_o <= 10'h000;
      ctrl_phase_o <= 1'b0;
      word_len_o <= 5'd20;
    end else begin
      // codes 000 and 100 both mean off
      spread_code_o <= (phase_q != st_video || spread_q[6:5] == 2'b00)
                     ? 3'h0 : spread_q[7:5]; // [R12] [R15] [R16]
      filter_bypass_o <= edge_q[`EDGE_BYPASS_BIT]; // [R18]
      boost_level_o <= boost_q[7:5]; // [R19]
      gpio_out_o <= gpio_val_q & gpio_avail; // [R24]
      gpio_oe_o <= gpio_dir_q & gpio_avail; // [R24]
      ctrl_phase_o <= (phase_q != st_video);
      word_len_o <= len; // [R6]
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  len_legal_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    len inside {5'd12, 5'd14, 5'd16, 5'd18, 5'd20}) // [R6]
    else $error("illegal word length");
  lsb_first_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !load |=> serial_out_positive_o == $past(sh_q[0])) // [R1]
    else $error("bit order wrong");
  gpio_mask_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (fmt_q[2] && !fmt_q[`FMT_PAR_BIT]) |=> gpio_oe_o[7:0] == 8'h00) // [R24]
    else $error("unavailable gpio driven");
  gpio_fixed_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    gpio_avail[9:8] == 2'b11) // [R23]
    else $error("gpio 8 or 9 missing");
  spread_ctrl_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ##1 $past(phase_q) != st_video |-> spread_code_o == 3'h0) // [R16]
    else $error("spread in control phase");
  vs_enter_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (phase_q == st_video && vs_active) |=> phase_q == st_control) // [R21]
    else $error("no control entry");
  bypass_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ##1 filter_bypass_o == $past(edge_q[`EDGE_BYPASS_BIT])) // [R18]
    else $error("bypass not following");
  boost_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    boost_o |-> serial_out_positive_o != $past(serial_out_positive_o))
    else $error("boost without transition"); // [R19]
endmodule
`default_nettype wire

// >>> rtl/video_framer_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef VIDEO_FRAMER_REGS_SVH
`define VIDEO_FRAMER_REGS_SVH
`define ADDR_LINK_FORMAT 8'h00
`define ADDR_SPREAD_SEL 8'h04
`define ADDR_EDGE_FILTER 8'h10
`define ADDR_DRIVE_BOOST 8'h30
`define ADDR_STATUS 8'h38
`define ADDR_GPIO_CTRL 8'h3C
`define RST_LINK_FORMAT 8'hB5
`define RST_SPREAD_SEL 8'h1F
`define RST_EDGE_FILTER 8'h28
`define RST_DRIVE_BOOST 8'hE0
`define FMT_PAR_BIT 3
`define EDGE_VSYNC_BIT 7
`define EDGE_CLK_BIT 5
`define EDGE_BYPASS_BIT 2
`define HSK_SHORT 16'h0222
`define HSK_LONG 16'h0442
`define SYNC_HOLD_CYC 4'h8
`endif

// >>> rtl/video_framer_pkg.sv
// types shared by the serial word framer
package video_framer_pkg;
  typedef enum logic [1:0] {
    st_video,
    st_control,
    st_handshake
  } link_phase_t;
endpackage

// >>> tb/link_partner_model.sv
// far-end model: aligns to serial words and checks their content
`default_nettype none
module link_partner_model (
  input wire logic mclk_i, // bit clock
  input wire logic clr_i, // clears the counters
  input wire logic ser_p_i, // serial pair, true side
  input wire logic ser_n_i, // serial pair, inverted side
  input wire logic boost_i, // preemphasis flag
  input wire logic [4:0] len_i, // expected word length
  input wire logic par_i, // parity pair expected
  input wire logic hs_i, // expected horizontal sync
  input wire logic vs_i, // expected vertical sync
  input wire logic [15:0] data_i, // expected video data
  output int n_word_o, // words recognised
  output int n_err_o, // spacing, coding or pair faults
  output int n_boost_o // boost flag faults
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // word recogniser
  // ----------------------------------------
  logic [19:0] sr_q; // newest bit enters at the top
  logic prev_q; // previous line level
  logic code_q; // coding bit of the last word
  int gap_q = 0; // cycles since the last word
  logic [19:0] win; // last len bits, first sent at bit 0
  logic hit0, hit1; // word seen with either coding polarity
  // expected word for one coding polarity
  function automatic logic [19:0] build(input logic c);
    logic [19:0] core;
    logic p;
    int lc;
    lc = int'(len_i) - (par_i ? 2 : 0);
    core = ({4'h0, data_i} << 4) | {16'h0, vs_i, hs_i, ~c, c};
    core = core & ((20'h1 << lc) - 20'h1);
    p = ^core;
    build = par_i ? {core[17:0], ~p, p} : core;
  endfunction
  assign win = sr_q >> (5'd20 - len_i);
  assign hit0 = (win == build(1'b0));
  assign hit1 = (win == build(1'b1));
  // shift in, recognise, count; a stuck coding bit breaks dc balance
  always @(posedge mclk_i) begin
    sr_q <= {ser_p_i, sr_q[19:1]}; // lsb arrives first
    prev_q <= ser_p_i;
    gap_q <= gap_q + 1;
    if (clr_i) begin
      n_word_o <= 0;
      n_err_o <= 0;
      n_boost_o <= 0;
    end else begin
      if (ser_n_i !== ~ser_p_i)
        n_err_o <= n_err_o + 1;
      if (boost_i !== (ser_p_i != prev_q))
        n_boost_o <= n_boost_o + 1;
      if (hit0 || hit1) begin
        n_word_o <= n_word_o + 1;
        if (n_word_o > 0 && (gap_q != int'(len_i) || code_q == hit1))
          n_err_o <= n_err_o + 1;
      end
    end
    if (hit0 || hit1) begin
      gap_q <= 1;
      code_q <= hit1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/video_serial_word_framer_bench.sv
// bench: registers, word framing, control phase and gpio masking
`include "video_framer_regs.svh"
`default_nettype none
module video_serial_word_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 40000; // cycle ceiling for the whole run
  localparam int CTRLW = 4; // shortened control phase
  localparam int HSKW = 8; // shortened handshake
  // ----------------------------------------
  // pins and bench state
  // ----------------------------------------
  logic mclk_i = 1'b0, reset_n_i = 1'b0, pclk_pin_i = 1'b0;
  logic hsync_i = 1'b1, vsync_i = 1'b1; // syncs idle high
  logic [15:0] data_i = 16'hB3C5;
  logic [9:0] gpio_in_i = 10'h155;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serial_out_positive_o, serial_out_negative_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  logic boost_o, filter_bypass_o, ctrl_phase_o;
  logic [2:0] boost_level_o, spread_code_o;
  logic [9:0] gpio_out_o, gpio_oe_o;
  logic [4:0] word_len_o;
  int n_mismatch = 0, tests_run = 0, cyc = 0, ctrl_cyc = 0;
  int plen = 20, pcnt = 0, n_word, n_err, n_boost;
  logic par_e = 1'b0, clr = 1'b0;
  logic [15:0] dat_r = 16'hB3C5, dat_f = 16'hB3C5, exp_d = 16'hB3C5;
  always #5 mclk_i = ~mclk_i;
  video_serial_word_framer #(.HSK_WORDS(HSKW), .CTRL_WORDS(CTRLW)) u_dut (
    .mclk_i, .reset_n_i, .pclk_pin_i, .hsync_i, .vsync_i, .data_i,
    .gpio_in_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_out_positive_o,
    .serial_out_negative_o, .boost_o, .boost_level_o, .spread_code_o,
    .filter_bypass_o, .gpio_out_o, .gpio_oe_o, .ctrl_phase_o, .word_len_o);
  link_partner_model u_far (.mclk_i(mclk_i), .clr_i(clr),
    .ser_p_i(serial_out_positive_o), .ser_n_i(serial_out_negative_o),
    .boost_i(boost_o), .len_i(5'(plen)), .par_i(par_e), .hs_i(hsync_i),
    .vs_i(vsync_i), .data_i(exp_d), .n_word_o(n_word), .n_err_o(n_err),
    .n_boost_o(n_boost));
  // pixel clock, one word per plen bits; data differs on each edge
  always @(posedge mclk_i) begin
    pcnt <= (pcnt + 1 >= plen) ? 0 : pcnt + 1;
    pclk_pin_i <= (pcnt < plen / 2);
    if (pcnt == plen / 4)
      data_i <= dat_f;
    if (pcnt == plen / 2 + plen / 4)
      data_i <= dat_r;
  end
  // hang guard and control-phase length meter
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (ctrl_phase_o === 1'b1)
      ctrl_cyc <= ctrl_cyc + 1;
    if (cyc == TMO) begin
      n_mismatch++;
      test_done();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge mclk_i);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge mclk_i);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge mclk_i);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (b !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, rv;
    @(posedge mclk_i);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge mclk_i);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid & s_axi_rready;
      rsp = s_axi_rresp;
      rdat = s_axi_rdata;
      @(posedge mclk_i);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (rv !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic set_fmt(input logic [7:0] f, input int len);
    axi_wr(`ADDR_LINK_FORMAT, {24'h0, f});
    plen <= len; // far end and pixel clock follow together
    par_e <= f[`FMT_PAR_BIT];
  endtask
  // settle, then count clean words over eight word times
  task automatic stream_chk();
    repeat (16 * plen) @(posedge mclk_i);
    clr <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
    repeat (8 * plen) @(posedge mclk_i);
    chk(32'(n_word > 5), 32'h1);
    chk(32'(n_err), 32'h0);
    chk(32'(n_boost), 32'h0);
  endtask
  task automatic wait_ctrl(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (ctrl_phase_o !== v && n < lim);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ra [4];
    logic [7:0] rv [4];
    ra = '{`ADDR_LINK_FORMAT, `ADDR_SPREAD_SEL, `ADDR_EDGE_FILTER,
      `ADDR_DRIVE_BOOST};
    rv = '{`RST_LINK_FORMAT, `RST_SPREAD_SEL, `RST_EDGE_FILTER,
      `RST_DRIVE_BOOST};
    for (int i = 0; i < 4; i++) begin
      axi_rd(ra[i]);
      chk(32'(rdat[7:0]), 32'(rv[i]));
      chk(32'(rsp), 32'h0);
    end
    axi_rd(8'h08); // hole in the map
    chk(32'(rsp), 32'h2);
    axi_wr(8'h08, 32'hFF);
    chk(32'(rsp), 32'h2);
    @(negedge mclk_i);
    chk(32'(word_len_o), 32'd20);
    chk(32'(boost_level_o), 32'h7);
    chk(32'(filter_bypass_o), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_format();
    logic [2:0] wc;
    logic par;
    int len;
    logic [7:0] f;
    for (int k = 0; k < 12; k++) begin
      wc = (k < 8) ? k[2:0] : 3'(k - 8);
      par = (k >= 8);
      len = (wc[2] ? 20 : 12 + 2 * wc[1:0]) + (par ? 2 : 0);
      f = {2'(k), 2'(k + 1), par, wc};
      set_fmt(f, len);
      axi_rd(`ADDR_LINK_FORMAT);
      chk(32'(rdat[7:0]), 32'(f));
      @(negedge mclk_i);
      chk(32'(word_len_o), 32'(len));
      stream_chk();
    end
    $display("test format done");
  endtask
  task automatic t_edge();
    set_fmt(`RST_LINK_FORMAT, 20);
    dat_f <= 16'h4E1A;
    stream_chk(); // rising edge latches dat_r
    axi_wr(`ADDR_EDGE_FILTER, 32'h08);
    exp_d <= 16'h4E1A;
    stream_chk(); // falling edge latches dat_f
    axi_wr(`ADDR_EDGE_FILTER, 32'h2C);
    exp_d <= dat_r;
    @(negedge mclk_i);
    chk(32'(filter_bypass_o), 32'h1);
    axi_wr(`ADDR_EDGE_FILTER, 32'h28);
    dat_f <= dat_r;
    @(negedge mclk_i);
    chk(32'(filter_bypass_o), 32'h0);
    $display("test edge done");
  endtask
  task automatic t_misc();
    set_fmt(8'h35, 20); // low pixel range allows every spread
    for (int c = 0; c < 8; c++) begin
      axi_wr(`ADDR_SPREAD_SEL, 32'(c * 32 + 31)); // far end never
      axi_wr(`ADDR_DRIVE_BOOST, 32'(c * 32));
      @(negedge mclk_i);
      chk(32'(spread_code_o), (c % 4 == 0) ? 32'h0 : 32'(c));
      chk(32'(boost_level_o), 32'(c));
    end
    axi_wr(`ADDR_SPREAD_SEL, 32'h1F);
    set_fmt(`RST_LINK_FORMAT, 20);
    stream_chk();
    $display("test misc done");
  endtask
  task automatic t_vsync();
    int c0;
    axi_wr(`ADDR_SPREAD_SEL, 32'h3F); // 1.5 percent, legal here
    vsync_i <= 1'b0;
    wait_ctrl(1'b1, 4 * plen);
    chk(32'(ctrl_phase_o), 32'h1);
    chk(32'(spread_code_o), 32'h0);
    c0 = ctrl_cyc;
    repeat (8 * plen) @(posedge mclk_i);
    vsync_i <= 1'b1; // inactive edge only after eight pixels
    wait_ctrl(1'b0, 20 * plen);
    c0 = ctrl_cyc - c0;
    chk(32'(c0 >= (CTRLW + HSKW - 1) * plen
      && c0 <= (CTRLW + HSKW + 2) * plen), 32'h1);
    chk(32'(spread_code_o), 32'h1);
    axi_wr(`ADDR_EDGE_FILTER, 32'hA8); // rising edge now active
    vsync_i <= 1'b0;
    wait_ctrl(1'b1, 4 * plen);
    chk(32'(ctrl_phase_o), 32'h0);
    @(posedge mclk_i);
    vsync_i <= 1'b1;
    wait_ctrl(1'b1, 4 * plen);
    chk(32'(ctrl_phase_o), 32'h1);
    wait_ctrl(1'b0, 20 * plen);
    chk(32'(ctrl_phase_o), 32'h0);
    axi_wr(`ADDR_EDGE_FILTER, 32'h28);
    axi_wr(`ADDR_SPREAD_SEL, 32'h1F);
    $display("test vsync done");
  endtask
  task automatic t_gpio();
    axi_wr(`ADDR_GPIO_CTRL, 32'h03FF_02AA); // all driven, alternating
    @(negedge mclk_i);
    chk(32'(gpio_oe_o), 32'h300);
    chk(32'(gpio_out_o), 32'h200);
    set_fmt(8'hB0, 12); // eight-bit width frees every shared pin
    @(negedge mclk_i);
    chk(32'(gpio_oe_o), 32'h3FF);
    chk(32'(gpio_out_o), 32'h2AA);
    axi_rd(`ADDR_STATUS);
    chk(rdat, 32'h0000_AAB0);
    stream_chk();
    $display("test gpio done");
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_format();
    t_edge();
    t_misc();
    t_vsync();
    t_gpio();
    test_done();
  end
endmodule
`default_nettype wire
